// ### cvf_pkg.sv
// How it works
// R01: host port valid count, high/low bytes
// R02: lower chain valid count, high/low bytes
// R03: upper chain valid response count, high byte
// R04: counters saturate at all ones
// R05: snapshot read latches port counters, clears live
// R06: byte registers read-only, reset zero
// R07: upper chain low byte follows high byte
// R08: discard counter in snapshot register triggers latch
// R09: count only frames passing all checks
package cvf_pkg;
	localparam logic [11:0] HOST_SNAP_IDX = 12'h26A;
	localparam logic [11:0] HOST_VALID_HIGH_IDX = 12'h26B;
	localparam logic [11:0] HOST_VALID_LOW_IDX = 12'h26C;
	localparam logic [11:0] LOWER_VALID_HIGH_IDX = 12'h26D;
	localparam logic [11:0] LOWER_VALID_LOW_IDX = 12'h26E;
	localparam logic [11:0] UPPER_VALID_HIGH_IDX = 12'h26F;
	localparam logic [11:0] UPPER_VALID_LOW_IDX = 12'h270;
	localparam logic [11:0] LOWER_SNAP_IDX = 12'h268;
	localparam logic [11:0] UPPER_SNAP_IDX = 12'h269;
	localparam int VALID_WIDTH = 16;
	localparam int DISCARD_WIDTH = 8;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam logic [31:0] READ_ZERO = 32'h0000_0000;
endpackage : cvf_pkg

// ### cvf_port_stats.sv
module cvf_port_stats
	import cvf_pkg::*;
#(
	parameter int VW = VALID_WIDTH,
	parameter int DW = DISCARD_WIDTH
) (
	input wire logic sys_clk, // clock
	input wire logic rst, // async reset
	input wire logic frameValid, // frame passed all checks
	input wire logic frameDiscard, // frame discarded
	input wire logic snapshot, // latch and clear
	output logic [VW-1:0] validSnap, // latched valid count
	output logic [DW-1:0] discardSnap // latched discard count
);
	typedef struct packed {
		logic [VW-1:0] validLive;
		logic [DW-1:0] discardLive;
		logic [VW-1:0] validSnap;
		logic [DW-1:0] discardSnap;
	} cvf_stat_t;
	cvf_stat_t st_reg;
	cvf_stat_t st_next;

	always_comb begin
		st_next = st_reg;
		if (frameValid && !(&st_reg.validLive)) begin // R09 R04
			st_next.validLive = st_reg.validLive + 1'b1;
		end
		if (frameDiscard && !(&st_reg.discardLive)) begin // R08
			st_next.discardLive = st_reg.discardLive + 1'b1;
		end
		if (snapshot) begin // R05
			st_next.validSnap = st_reg.validLive;
			st_next.discardSnap = st_reg.discardLive;
			// a frame in the snapshot cycle opens the next period
			st_next.validLive = {{(VW-1){1'b0}}, frameValid};
			st_next.discardLive = {{(DW-1){1'b0}}, frameDiscard};
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			st_reg <= '0; // R06
		end else begin
			st_reg <= st_next;
		end
	end

	assign validSnap = st_reg.validSnap;
	assign discardSnap = st_reg.discardSnap;

	saturate_hold_a: assert property (@(posedge sys_clk) disable iff (rst) // R04
		(&st_reg.validLive) && !snapshot |=> (&st_reg.validLive))
		else $error("valid counter left saturation");
	count_step_a: assert property (@(posedge sys_clk) disable iff (rst) // R09
		frameValid && !snapshot && !(&st_reg.validLive)
		|=> st_reg.validLive == $past(st_reg.validLive) + 1'b1)
		else $error("valid counter did not step by one");
	snap_latch_a: assert property (@(posedge sys_clk) disable iff (rst) // R05
		snapshot
		|=> st_reg.validSnap == $past(st_reg.validLive) && st_reg.validLive == {{(VW-1){1'b0}}, $past(frameValid)})
		else $error("snapshot did not latch and clear");
	no_count_a: assert property (@(posedge sys_clk) disable iff (rst) // R09
		!frameValid && !snapshot |=> st_reg.validLive == $past(st_reg.validLive))
		else $error("valid counter moved without a frame");
endmodule : cvf_port_stats

// ### cvf_counters.sv
// Local design decision: the APB interface to the registers.
module cvf_counters
	import cvf_pkg::*;
(
	input wire logic sys_clk, // clock
	input wire logic rst, // async reset
	input wire logic psel, // apb select
	input wire logic penable, // apb enable
	input wire logic pwrite, // apb direction
	input wire logic [15:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data, ignored
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error
	input wire logic [2:0] frameValid, // valid frame pulse: 0 host, 1 lower, 2 upper
	input wire logic [2:0] frameDiscard // discarded frame pulse, same order
);
	typedef struct packed {
		logic [31:0] rdata;
		logic ready;
		logic err;
	} cvf_bus_t;
	cvf_bus_t bus_reg;
	cvf_bus_t bus_next;
	logic [VALID_WIDTH-1:0] validSnap [3];
	logic [DISCARD_WIDTH-1:0] discardSnap [3];
	logic [2:0] snapshot;
	logic setup;
	logic [11:0] idx;
	logic aligned;
	logic accessRd;
	logic accessWr;

	assign setup = psel && !penable;
	assign idx = paddr[13:2];
	assign aligned = (paddr[1:0] == 2'b00) && (paddr[15:14] == 2'b00);
	assign accessRd = psel && penable && !pready && !pwrite;
	assign accessWr = psel && penable && !pready && pwrite;
	// snapshot fires on the read's setup cycle so the access phase sees fresh data
	assign snapshot[0] = setup && !pwrite && aligned && idx == HOST_SNAP_IDX; // R05 R08
	assign snapshot[1] = setup && !pwrite && aligned && idx == LOWER_SNAP_IDX; // R05 R08
	assign snapshot[2] = setup && !pwrite && aligned && idx == UPPER_SNAP_IDX; // R05 R08

	cvf_port_stats #(
		.VW(VALID_WIDTH),
		.DW(DISCARD_WIDTH)
	) uHostStats (
		.sys_clk(sys_clk),
		.rst(rst),
		.frameValid(frameValid[0]),
		.frameDiscard(frameDiscard[0]),
		.snapshot(snapshot[0]),
		.validSnap(validSnap[0]),
		.discardSnap(discardSnap[0])
	);

	cvf_port_stats #(
		.VW(VALID_WIDTH),
		.DW(DISCARD_WIDTH)
	) uLowerStats (
		.sys_clk(sys_clk),
		.rst(rst),
		.frameValid(frameValid[1]),
		.frameDiscard(frameDiscard[1]),
		.snapshot(snapshot[1]),
		.validSnap(validSnap[1]),
		.discardSnap(discardSnap[1])
	);

	cvf_port_stats #(
		.VW(VALID_WIDTH),
		.DW(DISCARD_WIDTH)
	) uUpperStats (
		.sys_clk(sys_clk),
		.rst(rst),
		.frameValid(frameValid[2]),
		.frameDiscard(frameDiscard[2]),
		.snapshot(snapshot[2]),
		.validSnap(validSnap[2]),
		.discardSnap(discardSnap[2])
	);

	always_comb begin
		bus_next = bus_reg;
		bus_next.ready = 1'b0;
		bus_next.err = 1'b0;
		if (psel && penable && !bus_reg.ready) begin
			bus_next.ready = 1'b1;
			bus_next.rdata = READ_ZERO;
			if (pwrite || !aligned) begin
				bus_next.err = 1'b1; // R06
			end else begin
				case (idx)
					HOST_SNAP_IDX: bus_next.rdata = {24'h000000, discardSnap[0]}; // R08
					LOWER_SNAP_IDX: bus_next.rdata = {24'h000000, discardSnap[1]}; // R08
					UPPER_SNAP_IDX: bus_next.rdata = {24'h000000, discardSnap[2]}; // R08
					HOST_VALID_HIGH_IDX: bus_next.rdata = {24'h000000, validSnap[0][15:8]}; // R01
					HOST_VALID_LOW_IDX: bus_next.rdata = {24'h000000, validSnap[0][7:0]}; // R01
					LOWER_VALID_HIGH_IDX: bus_next.rdata = {24'h000000, validSnap[1][15:8]}; // R02
					LOWER_VALID_LOW_IDX: bus_next.rdata = {24'h000000, validSnap[1][7:0]}; // R02
					UPPER_VALID_HIGH_IDX: bus_next.rdata = {24'h000000, validSnap[2][15:8]}; // R03
					UPPER_VALID_LOW_IDX: bus_next.rdata = {24'h000000, validSnap[2][7:0]}; // R07
					default: bus_next.err = 1'b1;
				endcase
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			bus_reg <= '0;
		end else begin
			bus_reg <= bus_next;
		end
	end

	assign prdata = bus_reg.rdata;
	assign pready = bus_reg.ready;
	assign pslverr = bus_reg.err;

	// bus answer and refusals
	ready_one_a: assert property (@(posedge sys_clk) disable iff (rst) // R06
		psel && penable && !pready
		|=> pready)
		else $error("access phase not answered next cycle");
	write_err_a: assert property (@(posedge sys_clk) disable iff (rst) // R06
		accessWr
		|=> pslverr)
		else $error("write to read-only bank not refused");
	write_zero_a: assert property (@(posedge sys_clk) disable iff (rst) // R06
		accessWr
		|=> prdata == READ_ZERO)
		else $error("refused write returned data");
	write_keep_a: assert property (@(posedge sys_clk) disable iff (rst) // R06
		psel && pwrite
		|=> validSnap[0] == $past(validSnap[0]) && validSnap[1] == $past(validSnap[1])
			&& validSnap[2] == $past(validSnap[2]))
		else $error("write changed a counter register");
	read_ok_a: assert property (@(posedge sys_clk) disable iff (rst) // R06
		accessRd && aligned && idx >= LOWER_SNAP_IDX && idx <= UPPER_VALID_LOW_IDX
		|=> !pslverr)
		else $error("mapped read refused");
	unmapped_a: assert property (@(posedge sys_clk) disable iff (rst) // R06
		accessRd && aligned && idx > UPPER_VALID_LOW_IDX
		|=> pslverr && prdata == READ_ZERO)
		else $error("unmapped read not refused");
	pulse_one_a: assert property (@(posedge sys_clk) disable iff (rst) // R06
		pready |=> !pready)
		else $error("ready held past one cycle");
	err_ready_a: assert property (@(posedge sys_clk) disable iff (rst) // R06
		pslverr |-> pready)
		else $error("error shown without ready");
	byte_wide_a: assert property (@(posedge sys_clk) disable iff (rst) // R06
		pready |-> prdata[31:8] == 24'h000000)
		else $error("read data wider than a byte");
	data_hold_a: assert property (@(posedge sys_clk) disable iff (rst) // R06
		!(psel && penable && !pready)
		|=> prdata == $past(prdata))
		else $error("read data changed outside an answer");
	idle_quiet_a: assert property (@(posedge sys_clk) disable iff (rst) // R06
		!psel |=> !pready)
		else $error("ready without a transfer");

	// byte views of the latched valid counts
	host_high_a: assert property (@(posedge sys_clk) disable iff (rst) // R01
		accessRd && paddr == {2'b00, HOST_VALID_HIGH_IDX, 2'b00}
		|=> prdata == {24'h000000, $past(validSnap[0][15:8])})
		else $error("host high byte read wrong");
	host_low_a: assert property (@(posedge sys_clk) disable iff (rst) // R01
		accessRd && paddr == {2'b00, HOST_VALID_LOW_IDX, 2'b00}
		|=> prdata == {24'h000000, $past(validSnap[0][7:0])})
		else $error("host low byte read wrong");
	lower_high_a: assert property (@(posedge sys_clk) disable iff (rst) // R02
		accessRd && paddr == {2'b00, LOWER_VALID_HIGH_IDX, 2'b00}
		|=> prdata == {24'h000000, $past(validSnap[1][15:8])})
		else $error("lower high byte read wrong");
	lower_low_a: assert property (@(posedge sys_clk) disable iff (rst) // R02
		accessRd && paddr == {2'b00, LOWER_VALID_LOW_IDX, 2'b00}
		|=> prdata == {24'h000000, $past(validSnap[1][7:0])})
		else $error("lower low byte read wrong");
	upper_high_a: assert property (@(posedge sys_clk) disable iff (rst) // R03
		accessRd && paddr == {2'b00, UPPER_VALID_HIGH_IDX, 2'b00}
		|=> prdata == {24'h000000, $past(validSnap[2][15:8])})
		else $error("upper high byte read wrong");
	upper_low_a: assert property (@(posedge sys_clk) disable iff (rst) // R07
		accessRd && paddr == {2'b00, UPPER_VALID_LOW_IDX, 2'b00}
		|=> prdata == {24'h000000, $past(validSnap[2][7:0])})
		else $error("upper low byte read wrong");

	// discard counts shown by the snapshot registers
	host_snap_a: assert property (@(posedge sys_clk) disable iff (rst) // R08
		accessRd && paddr == {2'b00, HOST_SNAP_IDX, 2'b00}
		|=> prdata == {24'h000000, $past(discardSnap[0])})
		else $error("host discard count read wrong");
	lower_snap_a: assert property (@(posedge sys_clk) disable iff (rst) // R08
		accessRd && paddr == {2'b00, LOWER_SNAP_IDX, 2'b00}
		|=> prdata == {24'h000000, $past(discardSnap[1])})
		else $error("lower discard count read wrong");
	upper_snap_a: assert property (@(posedge sys_clk) disable iff (rst) // R08
		accessRd && paddr == {2'b00, UPPER_SNAP_IDX, 2'b00}
		|=> prdata == {24'h000000, $past(discardSnap[2])})
		else $error("upper discard count read wrong");

	// a snapshot read touches its own port only
	host_only_a: assert property (@(posedge sys_clk) disable iff (rst) // R05
		setup && !pwrite && paddr == {2'b00, HOST_SNAP_IDX, 2'b00}
		|=> validSnap[1] == $past(validSnap[1]) && validSnap[2] == $past(validSnap[2]))
		else $error("host snapshot disturbed another port");
	lower_only_a: assert property (@(posedge sys_clk) disable iff (rst) // R05
		setup && !pwrite && paddr == {2'b00, LOWER_SNAP_IDX, 2'b00}
		|=> validSnap[0] == $past(validSnap[0]) && validSnap[2] == $past(validSnap[2]))
		else $error("lower snapshot disturbed another port");
	upper_only_a: assert property (@(posedge sys_clk) disable iff (rst) // R05
		setup && !pwrite && paddr == {2'b00, UPPER_SNAP_IDX, 2'b00}
		|=> validSnap[0] == $past(validSnap[0]) && validSnap[1] == $past(validSnap[1]))
		else $error("upper snapshot disturbed another port");
	host_hold_a: assert property (@(posedge sys_clk) disable iff (rst) // R05
		!snapshot[0]
		|=> validSnap[0] == $past(validSnap[0]) && discardSnap[0] == $past(discardSnap[0]))
		else $error("host latched counts moved without a snapshot");
	lower_hold_a: assert property (@(posedge sys_clk) disable iff (rst) // R05
		!snapshot[1]
		|=> validSnap[1] == $past(validSnap[1]) && discardSnap[1] == $past(discardSnap[1]))
		else $error("lower latched counts moved without a snapshot");
	upper_hold_a: assert property (@(posedge sys_clk) disable iff (rst) // R05
		!snapshot[2]
		|=> validSnap[2] == $past(validSnap[2]) && discardSnap[2] == $past(discardSnap[2]))
		else $error("upper latched counts moved without a snapshot");
endmodule : cvf_counters

// ### cvf_frame_src.sv
module cvf_frame_src (
	input wire logic sys_clk, // clock
	input wire logic [2:0] wantValid, // frames that pass all checks
	input wire logic [2:0] wantDiscard, // frames that get rejected
	output logic [2:0] frameValid, // valid frame pulse
	output logic [2:0] frameDiscard // rejected frame pulse
);
	timeunit 1ns;
	timeprecision 1ns;
	always_ff @(posedge sys_clk) begin
		frameValid <= wantValid;
		frameDiscard <= wantDiscard;
	end
endmodule : cvf_frame_src

// ### cvf_counters_tb.sv
module cvf_counters_tb;
	import cvf_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	logic sys_clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
	logic [15:0] paddr = 16'h0000;
	logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
	logic [2:0] wantValid = 3'h0, wantDiscard = 3'h0, frameValid, frameDiscard;
	int n_fail = 0, tests_run = 0;
	cvf_counters i_dut (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.frameValid(frameValid), .frameDiscard(frameDiscard));
	cvf_frame_src i_src (.sys_clk(sys_clk), .wantValid(wantValid), .wantDiscard(wantDiscard),
		.frameValid(frameValid), .frameDiscard(frameDiscard));
	initial forever #50 sys_clk = ~sys_clk;
	task automatic conclude();
		if (n_fail == 0 && tests_run > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask : conclude
	task automatic cmp(input logic [32:0] got, input logic [32:0] exp);
		tests_run++;
		if (got !== exp) begin
			n_fail++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask : cmp
	task automatic apb(input logic wr, input logic [11:0] idx);
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {2'b00, idx, 2'b00};
		@(posedge sys_clk);
		penable <= 1'b1;
		do begin
			@(posedge sys_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task automatic rchk(input logic [11:0] idx, input logic [7:0] exp);
		apb(1'b0, idx);
		cmp({err, rd}, {25'h0, exp});
	endtask : rchk
	task automatic send(input logic [2:0] v, input logic [2:0] d, input int n);
		repeat (n) begin
			@(posedge sys_clk);
			wantValid <= v;
			wantDiscard <= d;
		end
		@(posedge sys_clk);
		wantValid <= 3'h0;
		wantDiscard <= 3'h0;
	endtask : send
	task automatic t_reset();
		for (int i = 0; i < 6; i++) rchk(HOST_VALID_HIGH_IDX + 12'(i), BYTE_RESET);
	endtask : t_reset
	task automatic t_count();
		send(3'h7, 3'h0, 2);
		send(3'h3, 3'h4, 1);
		send(3'h1, 3'h2, 3);
		rchk(HOST_SNAP_IDX, 8'h00);
		rchk(LOWER_SNAP_IDX, 8'h03);
		rchk(UPPER_SNAP_IDX, 8'h01);
		rchk(HOST_VALID_LOW_IDX, 8'h06);
		rchk(LOWER_VALID_LOW_IDX, 8'h03);
		rchk(UPPER_VALID_HIGH_IDX, 8'h00);
		rchk(UPPER_VALID_LOW_IDX, 8'h02);
	endtask : t_count
	task automatic t_refuse();
		apb(1'b1, HOST_VALID_LOW_IDX);
		cmp({31'h0, err}, 33'h1);
		rchk(HOST_VALID_LOW_IDX, 8'h06);
		apb(1'b0, 12'h3FF);
		cmp({err, rd}, 33'h1_0000_0000);
	endtask : t_refuse
	task automatic t_clear();
		rchk(HOST_SNAP_IDX, 8'h00);
		rchk(HOST_VALID_LOW_IDX, 8'h00);
		rchk(LOWER_VALID_LOW_IDX, 8'h03);
		rchk(LOWER_SNAP_IDX, 8'h00);
		rchk(LOWER_VALID_LOW_IDX, 8'h00);
	endtask : t_clear
	task automatic t_sat();
		send(3'h1, 3'h2, 65537);
		rchk(HOST_SNAP_IDX, 8'h00);
		rchk(HOST_VALID_HIGH_IDX, 8'hFF);
		rchk(HOST_VALID_LOW_IDX, 8'hFF);
		rchk(LOWER_SNAP_IDX, 8'hFF);
		rchk(LOWER_VALID_LOW_IDX, 8'h00);
	endtask : t_sat
	task automatic t_rerst();
		@(posedge sys_clk);
		rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		rchk(HOST_VALID_HIGH_IDX, BYTE_RESET);
		rchk(HOST_VALID_LOW_IDX, BYTE_RESET);
	endtask : t_rerst
	initial begin
		#(100 * 90000);
		n_fail++;
		conclude();
	end
	initial begin
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		t_reset();
		t_count();
		t_refuse();
		t_clear();
		t_sat();
		t_rerst();
		conclude();
	end
endmodule : cvf_counters_tb
